// ### ctr_cond_pkg.sv
// Purpose: constants and carriers for the counter conditioning block
// Assumes: 40 MHz system clock, APB with 32-bit data
// Notes:   register offsets are byte addresses
package ctr_cond_pkg;

    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned FILT_CLK_HZ   = 40_000_000;
    localparam int unsigned FILT_N_SHORT  = 5;
    localparam int unsigned FILT_N_MID    = 257;
    localparam int unsigned FILT_N_LONG   = 101_800;
    localparam int unsigned FILT_CNT_W    = 17;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_PULSES = 8'h08;
    localparam logic [7:0] OFS_FILT   = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_COUNT  = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;

    // ctrl and cmd field positions
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_ARM_PIN   = 2;
    localparam int unsigned CTRL_STRIG     = 3;
    localparam int unsigned CTRL_PAUSE     = 4;
    localparam int unsigned CTRL_PAUSE_POL = 5;
    localparam int unsigned CTRL_CONT      = 6;
    localparam int unsigned CTRL_RETRIG    = 7;
    localparam int unsigned CTRL_SAMPEN    = 8;
    localparam int unsigned CTRL_PRE_LSB   = 9;
    localparam int unsigned CTRL_EXTSRC    = 11;
    localparam int unsigned CTRL_GSEL      = 12;
    localparam int unsigned CTRL_TOGGLE    = 13;
    localparam int unsigned CTRL_OUTPOL    = 14;
    localparam int unsigned CMD_ARM        = 0;
    localparam int unsigned CMD_STOP       = 1;

    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [31:0] PULSES_RST = 32'h0000_0001;
    localparam logic [1:0]  PRE_OFF = 2'h0;
    localparam logic [1:0]  PRE_2X  = 2'h1;
    localparam logic [1:0]  PRE_8X  = 2'h2;
    localparam logic [1:0]  FILT_OFF = 2'h0;
    localparam logic [1:0]  FILT_SHORT = 2'h1;
    localparam logic [1:0]  FILT_MID = 2'h2;
    localparam logic [1:0]  FILT_LONG = 2'h3;

    localparam logic [1:0] MODE_EDGE   = 2'h0;
    localparam logic [1:0] MODE_PERIOD = 2'h1;
    localparam logic [1:0] MODE_PULSE  = 2'h2;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_s;

endpackage

// ### ctr_cond.sv
// Purpose: trigger, filter, prescale and synchronous-count logic around one 32-bit counter
// Assumes: all inputs synchronous to clk_i; clk_i is the filter clock and the counting timebase
// Notes:   APB slave, zero wait states
//
// How it works
// - nothing counts, measures or generates until armed by software or hardware
// - hardware arm uses the routed trigger on the hardware arm input
// - start trigger launches finite or continuous pulse generation per type
// - continuous generation runs until software stop command
// - finite generation emits programmed pulses then halts; retrigger restarts it
// - start trigger arrives on the gate input; gate edge logic detects it
// - edge counting holds while pause inactive, counts when active; polarity selectable
// - continuous generation suspends output while pause inactive; polarity selectable
// - period runs rising gate to rising gate, counting source rises, after arm
// - with sample clock, result stored only if sample edge seen in period
// - no measurement taken or stored before arming
// - internal output and terminal count exported for the other counter's gate
// - enabled filters sample inputs each 40 MHz clock
// - level change passes after N consecutive equal samples, both directions
// - settings give N of 5, 257, 101800, or disabled
// - source, gate and arm filters set independently, sample clock filter always off; all disabled after reset
// - prescaler divides by 8, 2 or bypass; counter counts rollovers
// - prescaler count is never readable
// - prescaling applies only with an external source
// - each rising gate stores source pulses since previous rising gate
// - gate-sampled-by-source store belongs to the asynchronous mode, not used here
// - source and gate synchronised to timebase; gate edges seen without source pulses
// - one increment per source pulse; count and output change on timebase
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ctr_cond
    import ctr_cond_pkg::*;
#(
    parameter int unsigned FILT_LONG_N = FILT_N_LONG
)(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    input  wire logic        source_i,
    input  wire logic        gate_i,
    input  wire logic        hardware_arm_input_i,
    input  wire logic        sample_clk_i,
    input  wire logic        other_out_i,
    output logic             internal_out_o,
    output logic             terminal_count_pulse_o,
    output logic             store_pulse_o,
    output logic [31:0]      store_data_o
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_ff;
    logic [31:0] pulses_ff;
    logic [5:0]  filt_ff;
    logic [31:0] count_ff;
    logic [31:0] result_ff;
    logic        armed_ff;
    logic        running_ff;
    logic        done_ff;
    apb_rsp_s    rsp_ff;

    wire        wr_acc   = psel_i & penable_i & pwrite_i;
    wire        rd_acc   = psel_i & penable_i & ~pwrite_i;
    wire        wr_ctrl  = wr_acc & (paddr_i == OFS_CTRL);
    wire        wr_cmd   = wr_acc & (paddr_i == OFS_CMD);
    wire        wr_pul   = wr_acc & (paddr_i == OFS_PULSES);
    wire        wr_filt  = wr_acc & (paddr_i == OFS_FILT);
    wire        sw_arm   = wr_cmd & pwdata_i[CMD_ARM];
    wire        sw_stop  = wr_cmd & pwdata_i[CMD_STOP];
    wire [1:0]  mode     = ctrl_ff[CTRL_MODE_LSB +: 2];
    wire        arm_pin_en = ctrl_ff[CTRL_ARM_PIN];
    wire        strig_en = ctrl_ff[CTRL_STRIG];
    wire        pause_en = ctrl_ff[CTRL_PAUSE];
    wire        pause_pol = ctrl_ff[CTRL_PAUSE_POL];
    wire        cont     = ctrl_ff[CTRL_CONT];
    wire        retrig   = ctrl_ff[CTRL_RETRIG];
    wire        samp_en  = ctrl_ff[CTRL_SAMPEN];
    wire [1:0]  pre_sel  = ctrl_ff[CTRL_PRE_LSB +: 2];
    wire        ext_src  = ctrl_ff[CTRL_EXTSRC];
    wire        gate_sel = ctrl_ff[CTRL_GSEL];
    wire        toggle_m = ctrl_ff[CTRL_TOGGLE];
    wire        out_pol  = ctrl_ff[CTRL_OUTPOL];

    // ------------------------------------------------------------
    // debounce filters: source, gate, arm, sample clock
    // ------------------------------------------------------------
    function automatic logic [FILT_CNT_W-1:0] filt_n(input logic [1:0] s);
        unique case (s)
            FILT_SHORT: filt_n = FILT_CNT_W'(FILT_N_SHORT);
            FILT_MID:   filt_n = FILT_CNT_W'(FILT_N_MID);
            FILT_LONG:  filt_n = FILT_CNT_W'(FILT_LONG_N);
            default:    filt_n = FILT_CNT_W'(1);
        endcase
    endfunction

    wire [3:0] raw_in = {sample_clk_i, hardware_arm_input_i, gate_i, source_i};
    logic [3:0] filt_out;
    logic [1:0] filt_set [4];
    assign filt_set[0] = filt_ff[1:0];
    assign filt_set[1] = filt_ff[3:2];
    assign filt_set[2] = filt_ff[5:4];
    assign filt_set[3] = FILT_OFF;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_filt
            logic [FILT_CNT_W-1:0] run_ff;
            logic                  lvl_ff;
            wire  [FILT_CNT_W-1:0] nxt_run = (raw_in[gi] == lvl_ff) ? '0 : run_ff + 1'b1;
            wire                   pass = (filt_set[gi] == FILT_OFF)
                                          || (nxt_run >= filt_n(filt_set[gi]));
            always_ff @(posedge clk_i)
            begin
                if (!rstn_i)
                begin
                    run_ff <= '0;
                    lvl_ff <= 1'b0;
                end
                else if (ce_i)
                begin
                    // sample each clock; a sample equal to the held level resets the run
                    run_ff <= pass ? '0 : nxt_run;
                    if (pass)
                        lvl_ff <= raw_in[gi];
                end
            end
            assign filt_out[gi] = lvl_ff;
        end
    endgenerate

    // ------------------------------------------------------------
    // edge detect on timebase
    // ------------------------------------------------------------
    logic [3:0] prev_ff;
    wire        gate_lvl = gate_sel ? other_out_i : filt_out[1];
    wire        src_rise = filt_out[0] & ~prev_ff[0];
    wire        gate_rise = gate_lvl & ~prev_ff[1];
    wire        arm_rise = filt_out[2] & ~prev_ff[2];
    wire        samp_rise = filt_out[3] & ~prev_ff[3];
    wire        pause_ok = ~pause_en | (gate_lvl == pause_pol);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [2:0] pre_ff;
    wire  [1:0] pre_eff = ext_src ? pre_sel : PRE_OFF;
    wire  [2:0] pre_max = (pre_eff == PRE_8X) ? 3'h7 : (pre_eff == PRE_2X) ? 3'h1 : 3'h0;
    wire        tick = src_rise & (pre_ff >= pre_max);

    // ------------------------------------------------------------
    // arming and run control
    // ------------------------------------------------------------
    wire arm_evt  = sw_arm | (arm_pin_en & arm_rise);
    wire is_pulse = (mode == MODE_PULSE);
    wire start_ev = armed_ff & is_pulse & gate_rise
                    & (~running_ff | (~cont & retrig));
    wire go_now   = armed_ff & is_pulse & ~running_ff & ~strig_en & ~done_ff;
    wire last_p   = ~cont & (count_ff + 32'h1 >= pulses_ff);
    wire gen_adv  = running_ff & pause_ok & tick;
    logic samp_seen_ff;
    logic period_on_ff;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            armed_ff   <= 1'b0;
            running_ff <= 1'b0;
            done_ff    <= 1'b0;
            count_ff   <= '0;
            pre_ff     <= '0;
            prev_ff    <= '0;
            internal_out_o <= 1'b0;
            terminal_count_pulse_o <= 1'b0;
            store_pulse_o <= 1'b0;
            store_data_o  <= '0;
            result_ff  <= '0;
            samp_seen_ff <= 1'b0;
            period_on_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            prev_ff <= {filt_out[3], filt_out[2], gate_lvl, filt_out[0]};
            terminal_count_pulse_o <= 1'b0;
            store_pulse_o <= 1'b0;
            if (src_rise)
                pre_ff <= (pre_ff >= pre_max) ? 3'h0 : pre_ff + 3'h1;
            if (arm_evt)
            begin
                armed_ff <= 1'b1;
                done_ff  <= 1'b0;
                count_ff <= '0;
                period_on_ff <= 1'b0;
            end
            if (sw_stop)
            begin
                armed_ff   <= 1'b0;
                running_ff <= 1'b0;
                internal_out_o <= out_pol;
            end
            else if (start_ev | go_now)
            begin
                running_ff <= 1'b1;
                count_ff   <= '0;
            end
            else if (gen_adv)
            begin
                terminal_count_pulse_o <= 1'b1;
                internal_out_o <= toggle_m ? ~internal_out_o : ~out_pol;
                count_ff <= count_ff + 32'h1;
                if (last_p)
                begin
                    running_ff <= 1'b0;
                    done_ff    <= 1'b1;
                end
            end
            else if (is_pulse & ~toggle_m)
                internal_out_o <= out_pol;
            if (armed_ff & ~arm_evt & mode == MODE_EDGE & pause_ok & tick)
                count_ff <= count_ff + 32'h1;
            if (armed_ff & ~arm_evt & mode == MODE_PERIOD)
            begin
                if (samp_rise)
                    samp_seen_ff <= 1'b1;
                if (gate_rise)
                begin
                    period_on_ff <= 1'b1;
                    count_ff <= tick ? 32'h1 : 32'h0;
                    samp_seen_ff <= samp_rise;
                    if (period_on_ff & (~samp_en | samp_seen_ff))
                    begin
                        store_pulse_o <= 1'b1;
                        store_data_o  <= count_ff;
                        result_ff     <= count_ff;
                    end
                end
                else if (period_on_ff & tick)
                    count_ff <= count_ff + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    wire [31:0] status = {28'h0, period_on_ff, done_ff, running_ff, armed_ff};
    wire        addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= OFS_RESULT);
    wire [31:0] rd_mux =
        (paddr_i == OFS_CTRL)   ? ctrl_ff :
        (paddr_i == OFS_PULSES) ? pulses_ff :
        (paddr_i == OFS_FILT)   ? {26'h0, filt_ff} :
        (paddr_i == OFS_STATUS) ? status :
        (paddr_i == OFS_COUNT)  ? count_ff :
        (paddr_i == OFS_RESULT) ? result_ff : 32'h0;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl_ff   <= CTRL_RST;
            pulses_ff <= PULSES_RST;
            filt_ff   <= '0;
            rsp_ff    <= '0;
        end
        else if (ce_i)
        begin
            if (wr_ctrl)
                ctrl_ff <= pwdata_i;
            if (wr_pul)
                pulses_ff <= pwdata_i;
            if (wr_filt)
                filt_ff <= pwdata_i[5:0];
            rsp_ff.pready  <= psel_i & ~penable_i;
            rsp_ff.pslverr <= psel_i & ~penable_i & ~addr_ok;
            rsp_ff.prdata  <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h0;
        end
    end

    assign pready_o  = rsp_ff.pready;
    assign prdata_o  = rsp_ff.prdata;
    assign pslverr_o = rsp_ff.pslverr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_no_arm_store: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !armed_ff |=> !store_pulse_o)
        else $error("store without arm");
    a_samp_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && armed_ff && mode == MODE_PERIOD && samp_en && gate_rise && !samp_seen_ff
         && !arm_evt) |=> !store_pulse_o)
        else $error("store without sample edge");
    a_stop_halts: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && sw_stop) |=> !running_ff && !armed_ff)
        else $error("stop ignored");
    a_finite_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && gen_adv && last_p && !sw_stop && !start_ev && !go_now) |=> done_ff && !running_ff)
        else $error("finite run overran");
    a_pause_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && mode == MODE_EDGE && !pause_ok && !arm_evt) |=> $stable(count_ff))
        else $error("count moved while paused");
    a_filt_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> filt_ff == 6'h0)
        else $error("filter not off after reset");
    a_pre_bypass: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ext_src |-> (tick == src_rise))
        else $error("prescale on internal source");
    a_apb_ready: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && psel_i && !penable_i) |=> pready_o)
        else $error("apb no ready");
    a_filt_short: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ce_i && filt_ff[1:0] == FILT_SHORT && source_i != g_filt[0].lvl_ff
         && g_filt[0].run_ff < 17'h3) |=> $stable(g_filt[0].lvl_ff))
        else $error("filter passed early");

endmodule
`default_nettype wire

// ### ext_signals.sv
// Purpose: far-side model driving source, gate, arm, sample clock and the other counter's output
// Assumes: lines change right after a rising clk_i edge
// Notes:   idle level of every line is low; tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module ext_signals (
    input  wire logic clk_i,
    output logic      source_o,
    output logic      gate_o,
    output logic      arm_o,
    output logic      sample_o,
    output logic      other_o
);
    logic [4:0] lv_ff = 5'h00;

    assign source_o = lv_ff[0];
    assign gate_o   = lv_ff[1];
    assign arm_o    = lv_ff[2];
    assign sample_o = lv_ff[3];
    assign other_o  = lv_ff[4];

    // hi and lo set the high and low time of each pulse in clk_i cycles
    task automatic pulse(input int idx, input int hi, input int lo, input int reps);
        for (int r = 0; r < reps; r++)
        begin
            lv_ff[idx] <= 1'b1;
            repeat (hi) @(posedge clk_i);
            lv_ff[idx] <= 1'b0;
            repeat (lo) @(posedge clk_i);
        end
    endtask

    task automatic level(input int idx, input logic v);
        lv_ff[idx] <= v;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### test_counter_trigger_filter_prescale.sv
// Purpose: self-checking bench for the counter conditioning block
// Assumes: ce_i tied high; long filter shortened to 20 samples
// Notes:   lines: 0 source, 1 gate, 2 arm, 3 sample clock, 4 other counter
`timescale 1ns/1ps
`default_nettype none
module test_counter_trigger_filter_prescale;
    import ctr_cond_pkg::*;
    logic        clk_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1;
    logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, store_data_o, rd, last_store;
    logic        pready_o, pslverr_o, err, internal_out_o, term_o, store_pulse_o;
    logic        src, gate, arm, samp, other;
    int          n_mismatch = 0, comparisons = 0, n_term = 0, n_out = 0, n_store = 0;

    always #12.5 clk_i = ~clk_i;

    ctr_cond #(.FILT_LONG_N(20)) ctr_cond_inst (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .source_i(src), .gate_i(gate), .hardware_arm_input_i(arm), .sample_clk_i(samp),
        .other_out_i(other), .internal_out_o(internal_out_o), .terminal_count_pulse_o(term_o),
        .store_pulse_o(store_pulse_o), .store_data_o(store_data_o));
    ext_signals ext_signals_inst (.clk_i(clk_i), .source_o(src), .gate_o(gate), .arm_o(arm),
        .sample_o(samp), .other_o(other));

    always @(posedge clk_i)
    begin
        if (term_o === 1'b1)
            n_term++;
        if (internal_out_o === 1'b1)
            n_out++;
        if (store_pulse_o === 1'b1)
        begin
            n_store++;
            last_store = store_data_o;
        end
    end

    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            test_done();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic restart(input logic [31:0] ctrl);
        rstn_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b1, OFS_CTRL, ctrl);
    endtask

    // the generator counts source edges, so the source keeps pulsing while waiting
    task automatic wait_term(input int target);
        int n;
        for (n = 0; n < 300 && n_term < target; n++)
            ext_signals_inst.pulse(0, 2, 2, 1);
        if (n >= 300)
        begin
            n_mismatch++;
            test_done();
        end
        ext_signals_inst.pulse(0, 2, 2, 10);
    endtask

    function automatic logic [31:0] b(input int i);
        return 32'h0000_0001 << i;
    endfunction

    localparam logic [31:0] EXT = 32'h0000_0800;
    localparam logic [31:0] ARM = 32'h0000_0001;
    localparam logic [31:0] STOP = 32'h0000_0002;

    initial
    begin
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rd_chk("ctrl", OFS_CTRL, CTRL_RST);
        rd_chk("pulses", OFS_PULSES, PULSES_RST);
        rd_chk("filt", OFS_FILT, 32'h0);
        rd_chk("unmapped", 8'h1c, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        // edge counting: nothing before arm, long pulses count once
        apb(1'b1, OFS_CTRL, EXT);
        ext_signals_inst.pulse(0, 4, 3, 3);
        rd_chk("count unarmed", OFS_COUNT, 32'h0);
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 12, 3, 5);
        repeat (5) @(posedge clk_i);
        rd_chk("count armed", OFS_COUNT, 32'h5);
        // pause, active high
        restart(EXT | b(CTRL_PAUSE) | b(CTRL_PAUSE_POL));
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 3, 3, 3);
        ext_signals_inst.level(1, 1'b1);
        ext_signals_inst.pulse(0, 3, 3, 2);
        repeat (5) @(posedge clk_i);
        rd_chk("count paused", OFS_COUNT, 32'h2);
        // hardware arm
        restart(EXT | b(CTRL_ARM_PIN));
        ext_signals_inst.pulse(0, 3, 3, 2);
        ext_signals_inst.pulse(2, 3, 4, 1);
        ext_signals_inst.pulse(0, 3, 3, 3);
        repeat (5) @(posedge clk_i);
        rd_chk("count hardware_arm_input", OFS_COUNT, 32'h3);
        // prescalers count rollovers
        restart(EXT | {PRE_2X, 9'h0});
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 2, 3, 8);
        repeat (5) @(posedge clk_i);
        rd_chk("count 2x", OFS_COUNT, 32'h4);
        restart(EXT | {PRE_8X, 9'h0});
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 2, 3, 17);
        repeat (5) @(posedge clk_i);
        rd_chk("count 8x", OFS_COUNT, 32'h2);
        // filters: glitches below N are dropped, N=5 and shortened long setting
        restart(EXT);
        apb(1'b1, OFS_FILT, {30'h0, FILT_SHORT});
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 3, 10, 3);
        ext_signals_inst.pulse(0, 8, 10, 1);
        apb(1'b1, OFS_FILT, {30'h0, FILT_LONG});
        ext_signals_inst.pulse(0, 15, 30, 2);
        ext_signals_inst.pulse(0, 25, 30, 1);
        rd_chk("count filtered", OFS_COUNT, 32'h2);
        // period with sample clock
        restart(EXT | {30'h0, MODE_PERIOD} | b(CTRL_SAMPEN));
        ext_signals_inst.pulse(3, 3, 3, 1);
        ext_signals_inst.pulse(1, 4, 4, 2);
        chk("store unarmed", n_store, 0);
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(1, 4, 4, 1);
        chk("first gate", n_store, 0);
        ext_signals_inst.pulse(0, 3, 3, 3);
        ext_signals_inst.pulse(3, 3, 3, 1);
        ext_signals_inst.pulse(1, 4, 4, 1);
        chk("stores", n_store, 1);
        chk("period", last_store, 32'h3);
        ext_signals_inst.pulse(0, 3, 3, 2);
        ext_signals_inst.pulse(1, 4, 4, 1);
        chk("discard", n_store, 1);
        ext_signals_inst.pulse(3, 3, 3, 1);
        ext_signals_inst.pulse(1, 4, 4, 1);
        chk("stores empty", n_store, 2);
        rd_chk("result", OFS_RESULT, 32'h0);
        // cascade: other counter's output as gate
        restart(EXT | {30'h0, MODE_PERIOD} | b(CTRL_GSEL));
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(4, 4, 4, 1);
        ext_signals_inst.pulse(0, 3, 3, 2);
        ext_signals_inst.pulse(4, 4, 4, 1);
        chk("cascade", last_store, 32'h2);
        // finite retriggerable generation waits for the gate
        restart({30'h0, MODE_PULSE} | b(CTRL_STRIG) | b(CTRL_RETRIG));
        apb(1'b1, OFS_PULSES, 32'h2);
        n_term = 0;
        n_out = 0;
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 3, 3, 8);
        chk("no start", n_term, 0);
        ext_signals_inst.pulse(1, 4, 4, 1);
        wait_term(2);
        chk("finite", n_term, 2);
        ext_signals_inst.pulse(1, 4, 4, 1);
        wait_term(4);
        chk("retrig", n_term, 4);
        chk("out pulses", n_out, n_term);
        // continuous, held by the pause level, until stopped
        restart({30'h0, MODE_PULSE} | b(CTRL_CONT) | b(CTRL_PAUSE) | b(CTRL_PAUSE_POL));
        n_term = 0;
        n_out = 0;
        apb(1'b1, OFS_CMD, ARM);
        ext_signals_inst.pulse(0, 2, 2, 10);
        chk("paused", n_term, 0);
        ext_signals_inst.level(1, 1'b1);
        wait_term(10);
        apb(1'b1, OFS_CMD, STOP);
        rd = n_term;
        ext_signals_inst.pulse(0, 2, 2, 20);
        chk("stopped", n_term, rd);
        chk("out run", n_out, n_term);
        test_done();
    end

    initial
    begin
        #(25 * 100000);
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
